// [prc_map.svh]
// register offsets, field positions, reset values and timing counts for the reset/irq control block
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define PRC_ADDR_CTRL 8'hC0
`define PRC_ADDR_IRQ_SRC 8'hC1
`define PRC_ADDR_BTN_STAT 8'hC2
`define PRC_ADDR_SW_PC 8'hC3
`define PRC_ADDR_CAUSE 8'hC5
// ****************************************
// field positions
// ****************************************
`define PRC_BIT_ASSERT_EN 7
`define PRC_BIT_RELEASE_EN 6
`define PRC_BIT_WD_SR_EN 1
`define PRC_BIT_WD_PC_EN 0
`define PRC_BIT_ASSERT_FLAG 7
`define PRC_BIT_RELEASE_FLAG 6
`define PRC_BIT_LIVE_LEVEL 5
`define PRC_BIT_SW_PC 0
`define PRC_BIT_PC_FLAG 1
`define PRC_BIT_SR_FLAG 0
// ****************************************
// reset values and timing
// ****************************************
`define PRC_IRQ_SRC_RESET 8'hFF
`define PRC_ZERO_BYTE 8'h00
`define PRC_SW_PC_DELAY_US 8000
`define PRC_CLK_MHZ 25
`define PRC_SW_PC_CYCLES (`PRC_SW_PC_DELAY_US * `PRC_CLK_MHZ)
`define PRC_CNT_W 18
`endif

// [prc_pkg.sv]
// types shared by the reset/irq control block
package prc_pkg;
   // gray coded along idle -> wait -> fire
   typedef enum logic [1:0]
   {
      PRC_IDLE = 2'b00,
      PRC_WAIT = 2'b01,
      PRC_FIRE = 2'b11
   } prc_pc_state_e;
endpackage

// [prc_reset_irq_ctrl.sv]
// power-management system-control registers: watchdog recovery, button irqs, reset causes
`timescale 1ns/1ps
`include "prc_map.svh"
module prc_reset_irq_ctrl #(
   parameter int PC_DELAY_CYCLES = `PRC_SW_PC_CYCLES
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // system events
   input wire logic push_button_input_n_in,
   input wire logic wdog_expire_in,
   input wire logic sleep_entry_in,
   input wire logic irq_src_valid_in,
   input wire logic [7:0] irq_src_addr_in,
   input wire logic soft_reset_done_in,
   input wire logic power_cycle_done_in,
   // sequencer requests and button interrupt
   output logic soft_reset_start_out,
   output logic power_cycle_start_out,
   output logic button_irq_out
);
   // ****************************************
   // state
   // ****************************************
   logic [2:0] btn_sync_r, btn_sync_nxt;
   logic btn_level_r, btn_level_nxt;
   logic assert_en_r, assert_en_nxt, release_en_r, release_en_nxt;
   logic wd_sr_en_r, wd_sr_en_nxt, wd_pc_en_r, wd_pc_en_nxt;
   logic assert_flag_r, assert_flag_nxt, release_flag_r, release_flag_nxt;
   logic [7:0] irq_src_r, irq_src_nxt;
   logic sw_pc_r, sw_pc_nxt;
   logic pc_flag_r, pc_flag_nxt, sr_flag_r, sr_flag_nxt;
   logic [`PRC_CNT_W-1:0] cnt_r, cnt_nxt;
   prc_pkg::prc_pc_state_e st_r, st_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic sr_start_r, sr_start_nxt, pc_start_r, pc_start_nxt;
   logic rise, fall, wr_ctrl, wr_swpc, rd_src, rd_cause;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      // input is active low; a change counts once stages 2 and 3 agree
      btn_sync_nxt = {btn_sync_r[1:0], ~push_button_input_n_in};
      btn_level_nxt = (btn_sync_r[1] == btn_sync_r[2]) ? btn_sync_r[2] : btn_level_r;
      rise = btn_level_nxt & ~btn_level_r;
      fall = ~btn_level_nxt & btn_level_r;
      wr_ctrl = reg_wr_in & hit(reg_addr_in, `PRC_ADDR_CTRL);
      wr_swpc = reg_wr_in & hit(reg_addr_in, `PRC_ADDR_SW_PC);
      rd_src = reg_rd_in & hit(reg_addr_in, `PRC_ADDR_IRQ_SRC);
      rd_cause = reg_rd_in & hit(reg_addr_in, `PRC_ADDR_CAUSE);

      assert_en_nxt = wr_ctrl ? reg_wdata_in[`PRC_BIT_ASSERT_EN] : assert_en_r;
      release_en_nxt = wr_ctrl ? reg_wdata_in[`PRC_BIT_RELEASE_EN] : release_en_r;
      wd_sr_en_nxt = wr_ctrl ? reg_wdata_in[`PRC_BIT_WD_SR_EN] : wd_sr_en_r;
      wd_pc_en_nxt = wr_ctrl ? reg_wdata_in[`PRC_BIT_WD_PC_EN] : wd_pc_en_r;
      if (sleep_entry_in)
      begin
         // sleep wins over a same-cycle write
         wd_sr_en_nxt = 1'b0;
         wd_pc_en_nxt = 1'b0;
      end

      // status flags are sticky until a read of the source address
      assert_flag_nxt = assert_flag_r;
      release_flag_nxt = release_flag_r;
      irq_src_nxt = irq_src_r;
      if (rd_src)
      begin
         irq_src_nxt = `PRC_IRQ_SRC_RESET;
         assert_flag_nxt = 1'b0;
         release_flag_nxt = 1'b0;
      end
      if (irq_src_valid_in)
         irq_src_nxt = irq_src_addr_in;
      if (rise & assert_en_r)
         assert_flag_nxt = 1'b1;
      if (fall & release_en_r)
         release_flag_nxt = 1'b1;

      // watchdog expiry: power cycle takes priority over soft reset
      sr_start_nxt = wdog_expire_in & wd_sr_en_r & ~wd_pc_en_r;
      pc_start_nxt = wdog_expire_in & wd_pc_en_r;

      sw_pc_nxt = wr_swpc ? reg_wdata_in[`PRC_BIT_SW_PC] : sw_pc_r;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         prc_pkg::PRC_IDLE:
            if (sw_pc_r)
            begin
               st_nxt = prc_pkg::PRC_WAIT;
               cnt_nxt = '0;
            end
         prc_pkg::PRC_WAIT:
            if (cnt_r == `PRC_CNT_W'(PC_DELAY_CYCLES - 1))
               st_nxt = prc_pkg::PRC_FIRE;
            else
               cnt_nxt = cnt_r + `PRC_CNT_W'(1);
         prc_pkg::PRC_FIRE:
         begin
            pc_start_nxt = 1'b1;
            sw_pc_nxt = 1'b0;
            st_nxt = prc_pkg::PRC_IDLE;
         end
         default:
            st_nxt = prc_pkg::PRC_IDLE;
      endcase

      // set wins over the clear-on-read
      pc_flag_nxt = (pc_flag_r & ~rd_cause) | power_cycle_done_in;
      sr_flag_nxt = (sr_flag_r & ~rd_cause) | soft_reset_done_in;

      rdata_nxt = `PRC_ZERO_BYTE;
      case (reg_addr_in)
         `PRC_ADDR_CTRL:
         begin
            rdata_nxt[`PRC_BIT_ASSERT_EN] = assert_en_r;
            rdata_nxt[`PRC_BIT_RELEASE_EN] = release_en_r;
            rdata_nxt[`PRC_BIT_WD_SR_EN] = wd_sr_en_r;
            rdata_nxt[`PRC_BIT_WD_PC_EN] = wd_pc_en_r;
         end
         `PRC_ADDR_IRQ_SRC: rdata_nxt = irq_src_r;
         `PRC_ADDR_BTN_STAT:
         begin
            rdata_nxt[`PRC_BIT_ASSERT_FLAG] = assert_flag_r;
            rdata_nxt[`PRC_BIT_RELEASE_FLAG] = release_flag_r;
            rdata_nxt[`PRC_BIT_LIVE_LEVEL] = btn_level_r;
         end
         `PRC_ADDR_SW_PC: rdata_nxt[`PRC_BIT_SW_PC] = sw_pc_r;
         `PRC_ADDR_CAUSE:
         begin
            rdata_nxt[`PRC_BIT_PC_FLAG] = pc_flag_r;
            rdata_nxt[`PRC_BIT_SR_FLAG] = sr_flag_r;
         end
         default: rdata_nxt = `PRC_ZERO_BYTE;
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         btn_sync_r <= '0;
         btn_level_r <= 1'b0;
         assert_en_r <= 1'b0;
         release_en_r <= 1'b0;
         wd_sr_en_r <= 1'b0;
         wd_pc_en_r <= 1'b0;
         assert_flag_r <= 1'b0;
         release_flag_r <= 1'b0;
         irq_src_r <= `PRC_IRQ_SRC_RESET;
         sw_pc_r <= 1'b0;
         pc_flag_r <= 1'b0;
         sr_flag_r <= 1'b0;
         cnt_r <= '0;
         st_r <= prc_pkg::PRC_IDLE;
         rdata_r <= `PRC_ZERO_BYTE;
         sr_start_r <= 1'b0;
         pc_start_r <= 1'b0;
      end
      else if (clk_en_in)
      begin
         btn_sync_r <= btn_sync_nxt;
         btn_level_r <= btn_level_nxt;
         assert_en_r <= assert_en_nxt;
         release_en_r <= release_en_nxt;
         wd_sr_en_r <= wd_sr_en_nxt;
         wd_pc_en_r <= wd_pc_en_nxt;
         assert_flag_r <= assert_flag_nxt;
         release_flag_r <= release_flag_nxt;
         irq_src_r <= irq_src_nxt;
         sw_pc_r <= sw_pc_nxt;
         pc_flag_r <= pc_flag_nxt;
         sr_flag_r <= sr_flag_nxt;
         cnt_r <= cnt_nxt;
         st_r <= st_nxt;
         rdata_r <= rdata_nxt;
         sr_start_r <= sr_start_nxt;
         pc_start_r <= pc_start_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign soft_reset_start_out = sr_start_r;
   assign power_cycle_start_out = pc_start_r;
   assign button_irq_out = assert_flag_r | release_flag_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // a watchdog expiry may start a power cycle on its own, so the window keeps it out
   sequence s_sw_req;
      (clk_en_in && st_r == prc_pkg::PRC_IDLE && sw_pc_r && !wdog_expire_in) ##1 !wdog_expire_in;
   endsequence

   a_wdog_soft_start: assert property (clk_en_in && wdog_expire_in && wd_sr_en_r && !wd_pc_en_r |=> soft_reset_start_out)
      else $error("watchdog soft reset not started");
   a_sleep_clears_en: assert property (clk_en_in && sleep_entry_in |=> !wd_sr_en_r && !wd_pc_en_r)
      else $error("watchdog enables survived sleep");
   a_wdog_pc_start: assert property (clk_en_in && wdog_expire_in && wd_pc_en_r |=> power_cycle_start_out)
      else $error("watchdog power cycle not started");
   a_src_read_ones: assert property (clk_en_in && rd_src && !irq_src_valid_in |=> irq_src_r == `PRC_IRQ_SRC_RESET)
      else $error("source address not restored after read");
   a_assert_flag_set: assert property (clk_en_in && rise && assert_en_r |=> assert_flag_r)
      else $error("assertion flag not set");
   a_release_flag_set: assert property (clk_en_in && fall && release_en_r |=> release_flag_r)
      else $error("release flag not set");
   a_sw_pc_no_early: assert property (s_sw_req |-> !power_cycle_start_out [*2])
      else $error("software power cycle fired early");
   a_pc_flag_sticky: assert property (clk_en_in && power_cycle_done_in |=> pc_flag_r)
      else $error("power cycle flag lost");
   a_sr_flag_clear: assert property (clk_en_in && rd_cause && !soft_reset_done_in |=> !sr_flag_r)
      else $error("soft reset flag not cleared by read");
   a_assert_masked: assert property (clk_en_in && !assert_flag_r && !assert_en_r && !rd_src |=> !assert_flag_r)
      else $error("masked assertion set flag");
   a_release_masked: assert property (clk_en_in && !release_flag_r && !release_en_r && !rd_src |=> !release_flag_r)
      else $error("masked release set flag");
   a_level_stable: assert property (clk_en_in && btn_sync_r[1] != btn_sync_r[2] |=> $stable(btn_level_r))
      else $error("live level moved without agreement");
endmodule // prc_reset_irq_ctrl

// [prc_host_model.sv]
// host-side model that issues register reads and writes to the control block
`timescale 1ns/1ps
module prc_host_model
(
   // register bus towards the block
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial
   begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      // stale data would hide a write taken without its strobe
      wdata_out <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask
endmodule // prc_host_model

// [prc_reset_irq_ctrl_tb.sv]
// self-checking bench for the reset/irq control block
`timescale 1ns/1ps
module prc_reset_irq_ctrl_tb;
   localparam int PCD = 20;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] addr, wdata, rdata, got;
   logic [7:0] src = 8'h00;
   logic wr, rd, sr_st, pc_st, irq;
   logic pb_n = 1'b1, wd = 1'b0, slp = 1'b0, sv = 1'b0, srd = 1'b0, pcd = 1'b0;
   int fail_count = 0, comparisons = 0, cyc = 0, n_sr = 0, n_pc = 0, pc_at = 0, t0;
   int m_ctrl = 0, m_cause = 0;
   logic en = 1'b1;
   logic [7:0] src_q[$];
   prc_reset_irq_ctrl #(.PC_DELAY_CYCLES(PCD)) prc_reset_irq_ctrl_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .clk_en_in(en), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .push_button_input_n_in(pb_n), .wdog_expire_in(wd), .sleep_entry_in(slp),
      .irq_src_valid_in(sv), .irq_src_addr_in(src), .soft_reset_done_in(srd), .power_cycle_done_in(pcd),
      .soft_reset_start_out(sr_st), .power_cycle_start_out(pc_st), .button_irq_out(irq));
   prc_host_model prc_host_model_inst (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   initial
   begin
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      cyc++;
      if (sr_st === 1'b1)
         n_sr++;
      if (pc_st === 1'b1)
      begin
         n_pc++;
         pc_at = cyc;
      end
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      prc_host_model_inst.rd_reg(a, got);
      chk($sformatf("register %h", a), e, got);
   endtask
   // one-cycle event pulse: 0 expiry, 1 sleep, 2 source, 3 soft done, 4 cycle done
   task automatic ev(input int k);
      logic [7:0] r;
      @(posedge clk_in);
      case (k)
         0: wd <= 1'b1;
         1: slp <= 1'b1;
         2:
         begin
            r = 8'($urandom);
            src <= r;
            src_q.push_back(r);
            sv <= 1'b1;
         end
         3: srd <= 1'b1;
         default: pcd <= 1'b1;
      endcase
      @(posedge clk_in);
      {wd, slp, sv, srd, pcd} <= 5'h00;
      repeat (3) @(posedge clk_in);
   endtask
   initial
   begin
      repeat (5000) @(posedge clk_in);
      fail_count++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(19));
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdchk(8'hC1, 8'hFF);
      rdchk(8'hC5, 8'h00);
      rdchk(8'hC2, 8'h00);
      rdchk(8'h10, 8'h00);
      $display("test reset values done");
      m_ctrl = 8'hC2;
      prc_host_model_inst.wr_reg(8'hC0, 8'hFE);
      rdchk(8'hC0, 8'(m_ctrl));
      ev(0);
      chk("soft starts", 8'h01, 8'(n_sr));
      chk("cycle starts", 8'h00, 8'(n_pc));
      ev(3);
      m_cause = 1;
      rdchk(8'hC5, 8'(m_cause));
      rdchk(8'hC5, 8'h00);
      ev(1);
      m_ctrl = m_ctrl & 8'hC0;
      rdchk(8'hC0, 8'(m_ctrl));
      prc_host_model_inst.wr_reg(8'hC0, 8'h03);
      ev(0);
      chk("cycle starts", 8'h01, 8'(n_pc));
      chk("soft starts", 8'h01, 8'(n_sr));
      ev(4);
      m_cause = 2;
      rdchk(8'hC5, 8'(m_cause));
      rdchk(8'hC5, 8'h00);
      // both enables are set here; a frozen block must ignore the sleep pulse
      m_ctrl = 8'h03;
      en <= 1'b0;
      ev(1);
      en <= 1'b1;
      rdchk(8'hC0, 8'(m_ctrl));
      ev(1);
      m_ctrl = m_ctrl & 8'hC0;
      rdchk(8'hC0, 8'(m_ctrl));
      $display("test watchdog done");
      prc_host_model_inst.wr_reg(8'hC3, 8'h01);
      t0 = cyc;
      repeat (PCD + 12) @(posedge clk_in);
      chk("cycle starts", 8'h02, 8'(n_pc));
      chk("delay ok", 8'h01, 8'(pc_at - t0 >= PCD && pc_at - t0 <= PCD + 6));
      rdchk(8'hC3, 8'h00);
      $display("test software cycle done");
      prc_host_model_inst.wr_reg(8'hC0, 8'hC0);
      pb_n <= 1'b0;
      repeat (8) @(posedge clk_in);
      chk("irq", 8'h01, {7'h00, irq});
      rdchk(8'hC2, 8'hA0);
      rdchk(8'hC1, 8'hFF);
      rdchk(8'hC2, 8'h20);
      pb_n <= 1'b1;
      repeat (8) @(posedge clk_in);
      rdchk(8'hC2, 8'h40);
      rdchk(8'hC1, 8'hFF);
      prc_host_model_inst.wr_reg(8'hC0, 8'h00);
      pb_n <= 1'b0;
      repeat (8) @(posedge clk_in);
      chk("irq", 8'h00, {7'h00, irq});
      rdchk(8'hC2, 8'h20);
      $display("test button done");
      repeat (4)
      begin
         ev(2);
         rdchk(8'hC1, src_q.pop_front());
         rdchk(8'hC1, 8'hFF);
      end
      $display("test source address done");
      give_verdict();
   end
endmodule // prc_reset_irq_ctrl_tb
